// ### rtl/lui_change_det.sv
// Per-source change detector with sticky pending flag
`timescale 1ns/100ps
module lui_change_det (
  input  wire logic i_clock,     // System clock
  input  wire logic i_reset,     // Sync reset, active high
  lui_src_if.det    src          // Source status, enable, clear, pending
);
  logic prev_q;
  logic pend_q;
  wire  changed = src.status ^ prev_q;
  wire  set_ev  = changed & src.enable;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      prev_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      prev_q <= src.status;
      // Set wins over a read clear in the same cycle
      pend_q <= set_ev | (pend_q & ~src.clear);
    end
  end

  assign src.pending = pend_q;
endmodule : lui_change_det

// ### rtl/lui_ctrl.sv
// Top: termination/transmit control, interrupt enables, alarm status and interrupt output
`timescale 1ns/100ps
module lui_ctrl #(
  parameter longint LOOP_HOLD = lui_pkg::LOOP_HOLD_CYCLES
) (
  input  wire logic       i_clock,             // System clock, 50 MHz
  input  wire logic       i_reset,             // Sync reset, active high
  input  wire logic       i_wr_en,             // Host register write strobe
  input  wire logic       i_rd_en,             // Host register read strobe
  input  wire logic [4:0] i_addr,              // Host register address
  input  wire logic [7:0] i_wr_data,           // Host write data
  output logic      [7:0] o_rd_data,           // Host read data, registered
  input  wire logic       i_tx_line_clock,     // Transmit line clock, sampled as a level
  input  wire logic       i_internal_term,     // High: internal termination mode
  input  wire logic       i_driver_fail,       // Live driver monitor condition
  input  wire logic       i_fifo_near_limit,   // Jitter FIFO pointers within 3 bits
  input  wire logic       i_code_violation,    // Line code violation or excess zeros
  input  wire logic       i_loop_code_seen,    // Loop-up or loop-down code present now
  input  wire logic       i_all_ones,          // All-ones signal detected
  input  wire logic       i_signal_loss,       // Receive signal lost
  input  wire logic       i_pattern_sync,      // Synchronized to QRSS pattern
  output logic      [1:0] o_rx_resistor_sel,   // External receive resistor code
  output logic            o_tx_ratio_2_45,     // High: 1:2.45 ratio, low: 1:2
  output logic            o_violation_pulse,   // One-cycle bipolar violation request
  output logic            o_irq                // Interrupt output, active high
);
  logic [7:0] term_ctrl_q;
  logic [7:0] irq_mask_q;
  logic [7:0] rd_data_q;
  logic       viol_arm_q;
  logic       tx_line_clock_q;
  logic       viol_pulse_q;
  logic [lui_pkg::LOOP_CNT_W-1:0] loop_cnt_q;
  logic       loop_status_q;
  logic [1:0] rx_sel_q;
  logic       ratio_q;

  wire wr_term  = i_wr_en & (i_addr == lui_pkg::ADDR_TERM_CTRL);
  wire wr_mask  = i_wr_en & (i_addr == lui_pkg::ADDR_IRQ_MASK);
  wire rd_alarm = i_rd_en & (i_addr == lui_pkg::ADDR_ALARM);

  wire viol_bit  = term_ctrl_q[lui_pkg::VIOL_INSERT_BIT];
  wire tx_line_clock_rise = i_tx_line_clock & ~tx_line_clock_q;

  // Loop-code qualification over the hold time
  wire [lui_pkg::LOOP_CNT_W-1:0] loop_hold_w = lui_pkg::LOOP_CNT_W'(LOOP_HOLD);
  wire loop_qualified = (loop_cnt_q >= loop_hold_w);

  // Live status byte, reserved D7 zero
  wire [7:0] alarm_status = {1'b0,
                             i_driver_fail,
                             i_fifo_near_limit,
                             i_code_violation,
                             loop_status_q,
                             i_all_ones,
                             i_signal_loss,
                             i_pattern_sync};

  wire [7:0] rd_mux = (i_addr == lui_pkg::ADDR_TERM_CTRL) ? term_ctrl_q :
                      (i_addr == lui_pkg::ADDR_IRQ_MASK)  ? irq_mask_q  :
                      (i_addr == lui_pkg::ADDR_ALARM)     ? alarm_status : 8'h00;

  // Per-source change detectors
  logic [lui_pkg::NUM_SOURCES-1:0] pending;
  genvar g;
  generate
    for (g = 0; g < lui_pkg::NUM_SOURCES; g++) begin : g_src
      lui_src_if src_if ();
      assign src_if.status = alarm_status[g];
      assign src_if.enable = irq_mask_q[g];
      assign src_if.clear  = rd_alarm;
      assign pending[g]    = src_if.pending;
      lui_change_det u_det (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .src     (src_if)
      );
    end
  endgenerate

  // Register writes
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      term_ctrl_q <= lui_pkg::RESET_BYTE;
      irq_mask_q  <= lui_pkg::RESET_BYTE;
    end else begin
      if (wr_term)
        term_ctrl_q <= i_wr_data & lui_pkg::TERM_CTRL_WMASK;
      if (wr_mask)
        irq_mask_q <= i_wr_data;
    end
  end

  // Read data
  always_ff @(posedge i_clock) begin
    if (i_reset)
      rd_data_q <= lui_pkg::RESET_BYTE;
    else if (i_rd_en)
      rd_data_q <= rd_mux;
  end

  // Violation insert: armed by a 0-to-1 bit change, fired on a line clock rising edge.
  // A held 1 never re-arms, so the host must write 0 first.
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      tx_line_clock_q       <= 1'b0;
      viol_arm_q   <= 1'b0;
      viol_pulse_q <= 1'b0;
    end else begin
      tx_line_clock_q <= i_tx_line_clock;
      if (wr_term & i_wr_data[lui_pkg::VIOL_INSERT_BIT] & ~viol_bit)
        viol_arm_q <= 1'b1;
      else if (tx_line_clock_rise)
        viol_arm_q <= 1'b0;
      viol_pulse_q <= tx_line_clock_rise & viol_arm_q;
    end
  end

  // Loop-code timer; clears as soon as the code stops
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      loop_cnt_q    <= '0;
      loop_status_q <= 1'b0;
    end else if (!i_loop_code_seen) begin
      loop_cnt_q    <= '0;
      loop_status_q <= 1'b0;
    end else begin
      if (!loop_qualified)
        loop_cnt_q <= loop_cnt_q + 1'b1;
      loop_status_q <= loop_qualified;
    end
  end

  // Configuration outputs from flip-flops
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      rx_sel_q <= lui_pkg::RX_RES_NONE;
      ratio_q  <= 1'b0;
    end else begin
      rx_sel_q <= {term_ctrl_q[lui_pkg::RX_RES_HI_BIT], term_ctrl_q[lui_pkg::RX_RES_LO_BIT]};
      // Internal termination forces 1:2; external follows the bit, 0 = 1:2.45
      ratio_q  <= ~i_internal_term & ~term_ctrl_q[lui_pkg::TX_RATIO_BIT];
    end
  end

  assign o_rd_data         = rd_data_q;
  assign o_rx_resistor_sel = rx_sel_q;
  assign o_tx_ratio_2_45   = ratio_q;
  assign o_violation_pulse = viol_pulse_q;
  assign o_irq = irq_mask_q[lui_pkg::GLOBAL_IRQ_BIT] & (|pending);
endmodule : lui_ctrl

// ### rtl/lui_pkg.sv
// Package: register map, field positions, reset values and timing for the line unit control block
package lui_pkg;
  localparam logic [4:0] ADDR_TERM_CTRL = 5'h03;
  localparam logic [4:0] ADDR_IRQ_MASK  = 5'h04;
  localparam logic [4:0] ADDR_ALARM     = 5'h05;
  localparam logic [7:0] RESET_BYTE     = 8'h00;

  // Termination and transmit control fields
  localparam int RX_RES_HI_BIT   = 4;
  localparam int RX_RES_LO_BIT   = 3;
  localparam int VIOL_INSERT_BIT = 2;
  localparam int TX_RATIO_BIT    = 0;
  localparam logic [7:0] TERM_CTRL_WMASK = 8'h1F;

  // Enable and status bit positions
  localparam int GLOBAL_IRQ_BIT   = 7;
  localparam int DRIVER_FAIL_BIT  = 6;
  localparam int FIFO_LIMIT_BIT   = 5;
  localparam int CODE_VIOL_BIT    = 4;
  localparam int LOOP_CODE_BIT    = 3;
  localparam int ALL_ONES_BIT     = 2;
  localparam int SIGNAL_LOSS_BIT  = 1;
  localparam int PATTERN_SYNC_BIT = 0;
  localparam int NUM_SOURCES      = 7;

  // Receive resistor select encodings
  localparam logic [1:0] RX_RES_NONE   = 2'h0;
  localparam logic [1:0] RX_RES_60R    = 2'h1;
  localparam logic [1:0] RX_RES_52R5   = 2'h2;
  localparam logic [1:0] RX_RES_37R5   = 2'h3;

  // Loop-code qualification time
  localparam longint CLOCK_HZ          = 50000000;
  localparam longint LOOP_HOLD_SECONDS = 5;
  localparam longint LOOP_HOLD_CYCLES  = LOOP_HOLD_SECONDS * CLOCK_HZ;
  localparam int     LOOP_CNT_W        = 28;
endpackage : lui_pkg

// ### rtl/lui_src_if.sv
// Interface: one interrupt source between the top and its change detector
`timescale 1ns/100ps
interface lui_src_if;
  logic status;
  logic enable;
  logic clear;
  logic pending;
  modport top (output status, output enable, output clear, input pending);
  modport det (input status, input enable, input clear, output pending);
endinterface : lui_src_if

// ### tb/lui_ctrl_properties.sv
// Port-level assertions for the line unit control block
`timescale 1ns/100ps
module lui_ctrl_properties (
  input wire logic       i_clock,           // Clock
  input wire logic       i_reset,           // Reset
  input wire logic       i_wr_en,           // Write
  input wire logic       i_rd_en,           // Read
  input wire logic [4:0] i_addr,            // Address
  input wire logic [7:0] i_wr_data,         // Write data
  input wire logic [7:0] o_rd_data,         // Read data
  input wire logic       i_internal_term,   // Term mode
  input wire logic       i_loop_code_seen,  // Loop code
  input wire logic [1:0] o_rx_resistor_sel, // Resistor
  input wire logic       o_tx_ratio_2_45,   // Ratio
  input wire logic       o_violation_pulse, // Violation
  input wire logic       o_irq              // Interrupt
);
  logic [7:0] msk_q;
  logic [7:0] ctl_q;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  // Shadows of the writable registers
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      msk_q <= 8'h00;
      ctl_q <= 8'h00;
    end else if (i_wr_en) begin
      if (i_addr == 5'h04) msk_q <= i_wr_data;
      if (i_addr == 5'h03) ctl_q <= i_wr_data;
    end
  end
  // Status lags the code by a flop or two
  sequence s_code_gone;
    !i_loop_code_seen [*3] ##0 (i_rd_en && i_addr == 5'h05);
  endsequence
  a_irq_global: assert property (!msk_q[7] |-> !o_irq)
    else $error("irq without global enable");
  a_ratio_sel: assert property (!$past(i_reset) |-> o_tx_ratio_2_45 == (!$past(i_internal_term) && !$past(ctl_q[0])))
    else $error("ratio select wrong");
  a_resistor_sel: assert property (!$past(i_reset) |-> o_rx_resistor_sel == $past(ctl_q[4:3]))
    else $error("resistor select wrong");
  a_pulse_single: assert property (o_violation_pulse |=> !o_violation_pulse)
    else $error("violation pulse too long");
  a_status_reserved: assert property (i_rd_en && i_addr == 5'h05 |=> !o_rd_data[7])
    else $error("status bit 7 set");
  a_mask_readback: assert property (i_rd_en && i_addr == 5'h04 |=> o_rd_data == $past(msk_q))
    else $error("mask readback wrong");
  a_ctl_readback: assert property (i_rd_en && i_addr == 5'h03 |=> o_rd_data == ($past(ctl_q) & 8'h1F))
    else $error("control readback wrong");
  a_loop_clear: assert property (s_code_gone |=> !o_rd_data[3])
    else $error("loop status stuck");
endmodule : lui_ctrl_properties
bind lui_ctrl lui_ctrl_properties u_props (.i_clock(i_clock), .i_reset(i_reset), .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data),
  .i_internal_term(i_internal_term), .i_loop_code_seen(i_loop_code_seen), .o_irq(o_irq),
  .o_rx_resistor_sel(o_rx_resistor_sel), .o_tx_ratio_2_45(o_tx_ratio_2_45), .o_violation_pulse(o_violation_pulse));

// ### tb/lui_host.sv
// Host processor model on the register port
`timescale 1ns/100ps
module lui_host (
  input  wire logic       i_clock,   // Clock
  output logic            o_wr_en,   // Write
  output logic            o_rd_en,   // Read
  output logic      [4:0] o_addr,    // Address
  output logic      [7:0] o_wr_data, // Data out
  input  wire logic [7:0] i_rd_data  // Data in
);
  logic [7:0] q;
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 5'h00;
    o_wr_data = 8'h00;
  end
  task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_wr_en = w;
    o_rd_en = !w;
    o_addr = a;
    o_wr_data = d;
    @(negedge i_clock);
    q = i_rd_data;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_wr_data = ~d;  // Stale data must not look valid
  endtask : xfer
  // Zero first, so the next request is a fresh rising change
  task automatic fire();
    xfer(1'b1, 5'h03, 8'h00);
    xfer(1'b1, 5'h03, 8'h04);
  endtask : fire
endmodule : lui_host

// ### tb/tb_top.sv
// Self-checking bench for the line unit control block
`timescale 1ns/100ps
module tb_top;
  logic       clk;
  logic       rst;
  logic       lck;
  logic       term;
  logic [6:0] src;
  logic       wr;
  logic       rd;
  logic [4:0] addr;
  logic [7:0] wdat;
  logic [7:0] rdat;
  logic [1:0] rsel;
  logic       ratio;
  logic       pulse;
  logic       irq;
  int         miscompares = 0;
  int         comparisons = 0;
  lui_ctrl #(.LOOP_HOLD(16)) u_dut (.i_clock(clk), .i_reset(rst), .i_wr_en(wr), .i_rd_en(rd), .i_addr(addr),
    .i_wr_data(wdat), .o_rd_data(rdat), .i_tx_line_clock(lck), .i_internal_term(term), .i_driver_fail(src[6]),
    .i_fifo_near_limit(src[5]), .i_code_violation(src[4]), .i_loop_code_seen(src[3]), .i_all_ones(src[2]),
    .i_signal_loss(src[1]), .i_pattern_sync(src[0]), .o_rx_resistor_sel(rsel), .o_tx_ratio_2_45(ratio),
    .o_violation_pulse(pulse), .o_irq(irq));
  lui_host u_host (.i_clock(clk), .o_wr_en(wr), .o_rd_en(rd), .o_addr(addr), .o_wr_data(wdat), .i_rd_data(rdat));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
    u_host.xfer(1'b0, a, 8'h00);
    chk(u_host.q, e);
  endtask : rdchk
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic t_regs();
    rdchk(5'h03, 8'h00);
    rdchk(5'h04, 8'h00);
    u_host.xfer(1'b1, 5'h05, 8'hFF);
    rdchk(5'h05, 8'h00);
    rdchk(5'h1F, 8'h00);
    u_host.xfer(1'b1, 5'h03, 8'hFB);
    rdchk(5'h03, 8'h1B);
  endtask : t_regs
  task automatic t_sel();
    for (int k = 0; k < 8; k++) begin
      term = k[2];
      u_host.xfer(1'b1, 5'h03, 8'(k << 3) | 8'(k & 1));
      @(negedge clk);
      chk({6'h00, rsel}, 8'(k & 3));
      chk({7'h00, ratio}, {7'h00, !k[2] && !k[0]});
    end
    term = 1'b0;
    u_host.xfer(1'b1, 5'h03, 8'h00);
  endtask : t_sel
  task automatic pulses(input int e);
    int n;
    n = 0;
    for (int k = 0; k < 32; k++) begin
      @(negedge clk);
      lck = k[2];
      // Unknown counts as a pulse so it cannot hide
      if (pulse !== 1'b0) n++;
    end
    chk(8'(n), 8'(e));
  endtask : pulses
  task automatic t_viol();
    u_host.xfer(1'b1, 5'h03, 8'h04);
    pulses(1);
    u_host.xfer(1'b1, 5'h03, 8'h04);
    pulses(0);
    u_host.fire();
    pulses(1);
  endtask : t_viol
  // Each source: masked, globally masked, pending, cleared by read
  task automatic t_irq(input int b);
    logic [7:0] m;
    m = 8'h01 << b;
    u_host.xfer(1'b1, 5'h04, 8'hFF ^ m);
    src[b] = 1'b1;
    repeat (8) @(negedge clk);
    // Loop status must stay low until the hold time has run
    rdchk(5'h05, (b == 3) ? 8'h00 : m);
    repeat (12) @(negedge clk);
    rdchk(5'h05, m);
    chk({7'h00, irq}, 8'h00);
    u_host.xfer(1'b1, 5'h04, m);
    src[b] = 1'b0;
    repeat (20) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    u_host.xfer(1'b1, 5'h04, 8'h80 | m);
    chk({7'h00, irq}, 8'h01);
    rdchk(5'h05, 8'h00);
    @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    src[b] = 1'b1;
    repeat (20) @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    u_host.xfer(1'b1, 5'h04, 8'h00);
    src[b] = 1'b0;
    repeat (20) @(negedge clk);
    rdchk(5'h05, 8'h00);
  endtask : t_irq
  initial begin
    rst = 1'b1;
    lck = 1'b0;
    term = 1'b0;
    src = 7'h00;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_regs();
    t_sel();
    t_viol();
    for (int b = 0; b < 7; b++) t_irq(b);
    end_of_test();
  end
endmodule : tb_top
